// [rtl/rva_defs.svh]
/*
 vector map constants for the reset and vector address block.
 assumes inclusion by rtl/rva_pkg.sv and rtl/rva_vector_map.sv only.
*/
`ifndef RVA_DEFS_SVH
`define RVA_DEFS_SVH

`define RVA_ADDR_W        24
`define RVA_VEC_W         7
`define RVA_NUM_TRAPS     8
`define RVA_NUM_IRQS      118
`define RVA_NUM_SRC       126
`define RVA_RESET_ADDR    24'h000000
`define RVA_PRIMARY_BASE  24'h000000
`define RVA_ALT_BASE      24'h000100
`define RVA_ENTRY_OFS     24'h000004
`define RVA_CODE_START    24'h000200
`define RVA_IRQ_VEC_OFS   7'h08
`define RVA_TRAP_OSC      3'h1
`define RVA_TRAP_ADDR     3'h2
`define RVA_TRAP_STACK    3'h3
`define RVA_TRAP_MATH     3'h4
`define RVA_TRAP_DMA      3'h5
`define RVA_IRQ_EXT0      7'h00
`define RVA_IRQ_EXT1      7'h14
`define RVA_IRQ_EXT2      7'h1d
`define RVA_IRQ_EXT3      7'h35
`define RVA_IRQ_EXT4      7'h36
`define RVA_IRQ_DMA0      7'h04
`define RVA_IRQ_DMA1      7'h0e
`define RVA_IRQ_DMA2      7'h18
`define RVA_IRQ_DMA3      7'h24
`define RVA_IRQ_DMA4      7'h2e
`define RVA_IRQ_DMA5      7'h3d
`define RVA_IRQ_DMA6      7'h44
`define RVA_IRQ_DMA7      7'h45
`define RVA_IRQ_S1RX      7'h0b
`define RVA_IRQ_S1TX      7'h0c
`define RVA_IRQ_S1ERR     7'h41
`define RVA_IRQ_S2RX      7'h1e
`define RVA_IRQ_S2TX      7'h1f
`define RVA_IRQ_S2ERR     7'h42
`define RVA_IRQ_FIRST_NONE 7'h48
// request lines with no source, as a mask over request numbers 0..71
`define RVA_IRQ_NOSRC_MASK 72'h09_c600_2000_0004_8000

`endif

// [rtl/rva_pkg.sv]
/*
 types for the reset and vector address block.
 assumes rva_defs.svh is on the include path.
*/
`include "rva_defs.svh"

package rva_pkg;

	typedef logic [`RVA_ADDR_W-1:0] rva_addr_t;
	typedef logic [`RVA_VEC_W-1:0]  rva_vec_t;

	// core-facing answer: vector number and fetch address
	typedef struct packed {
		logic      valid;
		rva_vec_t  vec_num;
		rva_addr_t fetch_addr;
	} rva_vector_t;

	// peripheral request groups
	typedef struct packed {
		logic [4:0] ext_irq;
		logic [7:0] dma_irq;
		logic [2:0] serial1;
		logic [2:0] serial2;
	} rva_periph_req_t;

	typedef enum logic [1:0] {
		RVA_ST_RESET = 2'b00,
		RVA_ST_RUN   = 2'b01,
		RVA_ST_TAKEN = 2'b11
	} rva_state_t;

endpackage

// [rtl/rva_vector_map.sv]
/*
 reset entry and vector address generation: maps trap and interrupt
 requests to vector number and fetch address in the primary or alternate table.
 request lines with no source are masked here even when driven.
 the answer is registered: it shows one cycle after the accepting edge.
 assumes all inputs come from logic on core_clk_in; arbitration of user
 priority is done elsewhere and pending lines arrive already qualified.
 assumes the core loads the reset pc on the one-cycle load pulse.
*/
// Contract
// - reset is not an exception; no vector fetched at reset
// - reset clears registers and starts fetch at address zero
// - trap n maps to primary address 0x4 plus 2n, last 0x12
// - traps 1..5: oscillator, address, stack, math, dma; 0,6,7 reserved
// - request k maps to vector k+8, address 0x14 plus 2k
// - alternate table mirrors primary at offset 0x100
// - code starts at 0x200; never produced as vector fetch address
// - external inputs 0..4 raise requests 0, 20, 29, 53, 54
// - dma channels 0..7 raise requests 4,14,24,36,46,61,68,69
// - serial ports: 11,12,65 and 30,31,66 for rx, tx, error
// - requests 72..117 and listed gaps have no source
// - equal priority resolved by lowest table address
// - each entry holds a 24-bit handler start address
// - table select bit chooses alternate table when set
`timescale 1ns/1ps
`default_nettype none
`include "rva_defs.svh"

module rva_vector_map
(
	// clock and reset
	input  wire logic                       core_clk_in,
	input  wire logic                       rst_n_in,
	// trap sources
	input  wire logic                       osc_fail_trap_in,
	input  wire logic                       addr_err_trap_in,
	input  wire logic                       stack_err_trap_in,
	input  wire logic                       math_err_trap_in,
	input  wire logic                       dma_err_trap_in,
	// peripheral requests, already enabled and at the winning priority
	input  wire rva_pkg::rva_periph_req_t   periph_req_in,
	input  wire logic [`RVA_NUM_IRQS-1:0]   other_irq_in,
	// table select
	input  wire logic                       alt_table_select_in,
	// core exception handshake
	input  wire logic                       core_accept_in,
	// outputs to core
	output var  rva_pkg::rva_vector_t       vector_out,
	output var  rva_pkg::rva_addr_t         pc_load_out,
	output var  logic                       pc_load_valid_out,
	output var  logic                       pending_out
);

	logic [`RVA_NUM_SRC-1:0] src_req;
	logic [`RVA_NUM_IRQS-1:0] irq_req;
	logic [`RVA_NUM_IRQS-1:0] irq_live;
	logic [`RVA_NUM_TRAPS-1:0] trap_req;
	logic                      any_req;
	rva_pkg::rva_vec_t         win_vec;
	rva_pkg::rva_addr_t        table_base;
	rva_pkg::rva_addr_t        win_addr;
	rva_pkg::rva_state_t       state_ff;
	rva_pkg::rva_state_t       nxt_state;
	rva_pkg::rva_vector_t      vector_ff;
	rva_pkg::rva_vector_t      nxt_vector;
	rva_pkg::rva_addr_t        pc_ff;
	logic                      pc_valid_ff;
	logic                      pending_ff;
	rva_pkg::rva_addr_t        win_ofs;
	logic                      take;
	logic                      leaving_reset;

	// no-source mask over the request numbers below the reserved block
	localparam logic [`RVA_IRQ_FIRST_NONE-1:0] NOSRC_MASK = `RVA_IRQ_NOSRC_MASK;

	assign trap_req =
	{
		2'b00,
		dma_err_trap_in,
		math_err_trap_in,
		stack_err_trap_in,
		addr_err_trap_in,
		osc_fail_trap_in,
		1'b0
	};

	always_comb
	begin
		irq_req = other_irq_in;
		irq_req[`RVA_IRQ_EXT0]  = periph_req_in.ext_irq[0];
		irq_req[`RVA_IRQ_EXT1]  = periph_req_in.ext_irq[1];
		irq_req[`RVA_IRQ_EXT2]  = periph_req_in.ext_irq[2];
		irq_req[`RVA_IRQ_EXT3]  = periph_req_in.ext_irq[3];
		irq_req[`RVA_IRQ_EXT4]  = periph_req_in.ext_irq[4];
		irq_req[`RVA_IRQ_DMA0]  = periph_req_in.dma_irq[0];
		irq_req[`RVA_IRQ_DMA1]  = periph_req_in.dma_irq[1];
		irq_req[`RVA_IRQ_DMA2]  = periph_req_in.dma_irq[2];
		irq_req[`RVA_IRQ_DMA3]  = periph_req_in.dma_irq[3];
		irq_req[`RVA_IRQ_DMA4]  = periph_req_in.dma_irq[4];
		irq_req[`RVA_IRQ_DMA5]  = periph_req_in.dma_irq[5];
		irq_req[`RVA_IRQ_DMA6]  = periph_req_in.dma_irq[6];
		irq_req[`RVA_IRQ_DMA7]  = periph_req_in.dma_irq[7];
		irq_req[`RVA_IRQ_S1RX]  = periph_req_in.serial1[0];
		irq_req[`RVA_IRQ_S1TX]  = periph_req_in.serial1[1];
		irq_req[`RVA_IRQ_S1ERR] = periph_req_in.serial1[2];
		irq_req[`RVA_IRQ_S2RX]  = periph_req_in.serial2[0];
		irq_req[`RVA_IRQ_S2TX]  = periph_req_in.serial2[1];
		irq_req[`RVA_IRQ_S2ERR] = periph_req_in.serial2[2];
	end

	// lines with no source held inactive
	genvar gi;
	generate
		for (gi = 0; gi < `RVA_NUM_IRQS; gi = gi + 1)
		begin : g_live
			if (gi >= `RVA_IRQ_FIRST_NONE)
			begin : g_none
				assign irq_live[gi] = 1'b0;
			end
			else
			begin : g_src
				assign irq_live[gi] = irq_req[gi] & ~NOSRC_MASK[gi];
			end
		end
	endgenerate

	// vector number n sits at bit n; traps first then requests
	assign src_req = {irq_live, trap_req};
	assign any_req = |src_req;

	always_comb
	begin
		win_vec = '0;
		for (int i = `RVA_NUM_SRC - 1; i >= 0; i--)
		begin
			if (src_req[i])
			begin
				win_vec = 7'(i);
			end
		end
	end

	assign table_base = alt_table_select_in ? `RVA_ALT_BASE : `RVA_PRIMARY_BASE;
	// base plus entry offset plus twice vector number
	// largest result is 0x1fe, below start of code
	assign win_ofs  = {16'h0000, win_vec, 1'b0};
	assign win_addr = table_base + `RVA_ENTRY_OFS + win_ofs;
	// a live request meets the core's accept
	assign take = core_accept_in && any_req;
	assign leaving_reset = (state_ff == rva_pkg::RVA_ST_RESET);

	// answer registered in the accepting cycle's edge
	always_comb
	begin
		nxt_state = state_ff;
		nxt_vector = vector_ff;
		nxt_vector.valid = 1'b0;
		unique case (state_ff)
			rva_pkg::RVA_ST_RESET:
			begin
				nxt_state = rva_pkg::RVA_ST_RUN;
			end
			rva_pkg::RVA_ST_RUN, rva_pkg::RVA_ST_TAKEN:
			begin
				nxt_state = rva_pkg::RVA_ST_RUN;
				if (take)
				begin
					nxt_state = rva_pkg::RVA_ST_TAKEN;
					nxt_vector.valid = 1'b1;
					nxt_vector.vec_num = win_vec;
					nxt_vector.fetch_addr = win_addr;
				end
			end
			default:
			begin
				nxt_state = rva_pkg::RVA_ST_RESET;
			end
		endcase
	end

	always_ff @(posedge core_clk_in)
	begin
		// reset loads pc zero, fetches no vector
		if (!rst_n_in)
		begin
			state_ff    <= rva_pkg::RVA_ST_RESET;
			vector_ff   <= '0;
			pc_ff       <= `RVA_RESET_ADDR;
			pc_valid_ff <= 1'b0;
			pending_ff  <= 1'b0;
		end
		else
		begin
			state_ff    <= nxt_state;
			vector_ff   <= nxt_vector;
			pc_ff       <= pc_ff;
			pc_valid_ff <= 1'b0;
			pending_ff  <= any_req;
			// first cycle out of reset loads pc zero
			if (leaving_reset)
			begin
				pc_ff       <= `RVA_RESET_ADDR;
				pc_valid_ff <= 1'b1;
			end
		end
	end

	// 24-bit table entry address handed to the core for loading
	assign vector_out        = vector_ff;
	assign pc_load_out       = pc_ff;
	assign pc_load_valid_out = pc_valid_ff;
	assign pending_out       = pending_ff;

endmodule
`default_nettype wire

// [testbench/rva_vector_map_props.sv]
/* checker for the vector map top ports.
 assumes one clock, synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module rva_vector_map_props
(
	// clock and reset
	input wire logic	core_clk_in,
	input wire logic	rst_n_in,
	// requests and handshake
	input wire logic	osc_fail_trap_in,
	input wire logic	addr_err_trap_in,
	input wire logic	alt_table_select_in,
	input wire logic	core_accept_in,
	// answers
	input wire rva_pkg::rva_vector_t	vector_out,
	input wire rva_pkg::rva_addr_t	pc_load_out,
	input wire logic	pc_load_valid_out,
	input wire logic	pending_out
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);

	property p_pc_pulse; $rose(rst_n_in) |-> ##[0:1] pc_load_valid_out; endproperty
	a_pc_pulse: assert property (p_pc_pulse) else $error("no pc load after reset");
	property p_pc_zero; pc_load_valid_out |-> pc_load_out == 24'h000000; endproperty
	a_pc_zero: assert property (p_pc_zero) else $error("reset pc not zero");
	property p_pc_once; pc_load_valid_out |=> !pc_load_valid_out; endproperty
	a_pc_once: assert property (p_pc_once) else $error("pc load not a pulse");
	property p_no_vec; $rose(rst_n_in) |-> !vector_out.valid ##1 !vector_out.valid; endproperty
	a_no_vec: assert property (p_no_vec) else $error("vector issued by reset");
	property p_cause; vector_out.valid |-> $past(core_accept_in); endproperty
	a_cause: assert property (p_cause) else $error("vector without accept");
	property p_addr; vector_out.valid |-> vector_out.fetch_addr == ($past(alt_table_select_in) ?
		24'h000100 : 24'h000000) + 24'h000004 + {16'h0, vector_out.vec_num, 1'b0}; endproperty
	a_addr: assert property (p_addr) else $error("fetch address wrong");
	property p_below; vector_out.valid |-> vector_out.fetch_addr inside {[24'h000004:24'h0001fe]}; endproperty
	a_below: assert property (p_below) else $error("fetch address outside tables");
	property p_osc; $past(rst_n_in) && core_accept_in && osc_fail_trap_in
		|=> vector_out.valid && vector_out.vec_num == 7'h01; endproperty
	a_osc: assert property (p_osc) else $error("oscillator trap not vector 1");
	property p_adr; $past(rst_n_in) && core_accept_in && addr_err_trap_in && !osc_fail_trap_in
		|=> vector_out.vec_num == 7'h02; endproperty
	a_adr: assert property (p_adr) else $error("address trap not vector 2");
	property p_pend; osc_fail_trap_in |=> pending_out; endproperty
	a_pend: assert property (p_pend) else $error("live trap not shown pending");
endmodule
bind rva_vector_map rva_vector_map_props rva_vector_map_props_i (.core_clk_in, .rst_n_in, .osc_fail_trap_in,
	.addr_err_trap_in, .alt_table_select_in, .core_accept_in, .vector_out, .pc_load_out, .pc_load_valid_out,
	.pending_out);
`default_nettype wire

// [testbench/rva_core_model.sv]
/* core side: accepts while enabled, keeps the answer.
 assumes vector map outputs are registered. */
`timescale 1ns/1ps
`default_nettype none
module rva_core_model
(
	// clock and reset
	input wire logic	core_clk_in,
	input wire logic	rst_n_in,
	// bench control
	input wire logic	en_in,
	input wire logic	slow_in,
	// from the vector map
	input wire logic	pending_in,
	input wire rva_pkg::rva_vector_t	vector_in,
	// to map and bench
	output logic	accept_out,
	output logic	got_out,
	output rva_pkg::rva_vector_t	vec_out
);
	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
		begin
			accept_out <= 1'b0;
			got_out <= 1'b0;
			vec_out <= '0;
		end
		else
		begin
			// slow core skips every other cycle
			accept_out <= en_in && pending_in && !(slow_in && accept_out);
			got_out <= en_in && (got_out || vector_in.valid);
			if (en_in && vector_in.valid)
				vec_out <= vector_in;
		end
	end
endmodule
`default_nettype wire

// [testbench/rva_vector_map_tb.sv]
/* scenario bench for the vector map with a core model.
 assumes package, defs and core model compiled first. */
`timescale 1ns/1ps
`default_nettype none
module rva_vector_map_tb;
	localparam int S2 = 118;
	localparam int TRP = 137;
	logic	core_clk_in = 1'b0;
	logic	rst_n_in = 1'b0;
	logic [4:0]	trap = '0;
	rva_pkg::rva_periph_req_t	preq = '0;
	logic [117:0]	oirq = '0;
	logic	alt = 1'b0;
	logic	en = 1'b0;
	logic	slow = 1'b0;
	wire logic	accept;
	wire logic	got;
	wire logic	pcv;
	wire logic	pend;
	wire rva_pkg::rva_addr_t	pc;
	wire rva_pkg::rva_vector_t	vout;
	wire rva_pkg::rva_vector_t	vseen;
	int	errors = 0;
	int	n_compared = 0;

	rva_vector_map rva_vector_map_i (.core_clk_in, .rst_n_in, .osc_fail_trap_in(trap[0]),
		.addr_err_trap_in(trap[1]), .stack_err_trap_in(trap[2]), .math_err_trap_in(trap[3]),
		.dma_err_trap_in(trap[4]), .periph_req_in(preq), .other_irq_in(oirq), .alt_table_select_in(alt),
		.core_accept_in(accept), .vector_out(vout), .pc_load_out(pc), .pc_load_valid_out(pcv), .pending_out(pend));
	rva_core_model rva_core_model_i (.core_clk_in, .rst_n_in, .en_in(en), .slow_in(slow), .pending_in(pend),
		.vector_in(vout), .accept_out(accept), .got_out(got), .vec_out(vseen));

	always #12.5 core_clk_in = ~core_clk_in;

	function automatic logic [141:0] b(input int i);
		return 142'h1 << i;
	endfunction

	task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e)
		begin
			errors++;
			$display("Error %s expected %h seen %h", w, e, s);
		end
	endtask

	task automatic end_sim();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// drive {traps, peripherals, others}; v < 0 means no answer
	task automatic req(input logic [141:0] r, input logic a, input int v);
		int n;
		@(posedge core_clk_in);
		{trap, preq, oirq} <= r;
		alt <= a;
		en <= 1'b1;
		for (n = 0; n < 12 && got !== 1'b1; n++)
		begin
			@(posedge core_clk_in);
			#1;
		end
		chk("answered", got, v >= 0);
		if (v >= 0)
		begin
			chk("vec_num", vseen.vec_num, v);
			chk("fetch_addr", vseen.fetch_addr, (a ? 24'h000100 : 24'h0) + 24'h000004 + 24'(2 * v));
		end
		@(posedge core_clk_in);
		{trap, preq, oirq} <= '0;
		en <= 1'b0;
		repeat (3) @(posedge core_clk_in);
	endtask

	task automatic t_reset();
		int n;
		@(posedge core_clk_in);
		rst_n_in <= 1'b0;
		repeat (8) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		for (n = 0; n < 4 && pcv !== 1'b1; n++)
		begin
			@(posedge core_clk_in);
			#1;
		end
		chk("pc_load_valid", pcv, 1'b1);
		chk("pc_load", pc, 24'h000000);
		chk("vector_valid", vout.valid, 1'b0);
	endtask

	task automatic t_traps();
		for (int i = 1; i <= 5; i++)
			req(b(TRP + i - 1), i[0], i);
	endtask

	task automatic t_named();
		int q[19] = '{30, 31, 66, 11, 12, 65, 4, 14, 24, 36, 46, 61, 68, 69, 0, 20, 29, 53, 54};
		for (int i = 0; i < 19; i++)
			req(b(S2 + i), i[0], q[i] + 8);
	endtask

	task automatic t_other();
		req(b(1), 1'b0, 9);
		req(b(71), 1'b1, 79);
		req(b(117), 1'b0, -1);
		req(b(15), 1'b0, -1);
		req(b(64), 1'b1, -1);
		req(b(20), 1'b0, -1);
		req('0, 1'b1, -1);
	endtask

	task automatic t_prio();
		slow <= 1'b1;
		req(b(TRP + 2) | b(S2 + 14), 1'b0, 3);
		req(b(S2 + 6) | b(S2 + 3), 1'b1, 12);
		slow <= 1'b0;
	endtask

	initial
	begin
		t_reset();
		t_traps();
		t_named();
		t_other();
		t_prio();
		t_reset();
		end_sim();
	end

	// tests need about 360 cycles
	initial
	begin
		#(25 * 4000);
		errors++;
		end_sim();
	end
endmodule
`default_nettype wire
